// ==== core/sram_params.svh ====
// Constants for the host side of a 256K x 16 asynchronous static memory port.
// Assumes a 40 MHz controller clock; all figures are in ns unless noted.
`ifndef SRAM_PARAMS_SVH
`define SRAM_PARAMS_SVH

// ****************************************
// Geometry
// ****************************************
`define SRAM_ADDR_W          18
`define SRAM_DATA_W          16
`define SRAM_LANE_W          8

// ****************************************
// Clock
// ****************************************
`define SRAM_CLK_PERIOD_NS   25

// ****************************************
// Read timing, fast / slow grade
// ****************************************
`define SRAM_RD_PERIOD_FAST_NS    45
`define SRAM_RD_PERIOD_SLOW_NS    55
`define SRAM_ADDR_VALID_FAST_NS   45
`define SRAM_ADDR_VALID_SLOW_NS   55
`define SRAM_OE_VALID_FAST_NS     22
`define SRAM_OE_VALID_SLOW_NS     25
`define SRAM_LANE_VALID_FAST_NS   45
`define SRAM_LANE_VALID_SLOW_NS   55

// ****************************************
// Write timing, fast / slow grade
// ****************************************
`define SRAM_WR_PERIOD_FAST_NS    45
`define SRAM_WR_PERIOD_SLOW_NS    55
`define SRAM_WE_WIDTH_FAST_NS     35
`define SRAM_WE_WIDTH_SLOW_NS     40
`define SRAM_ADDR_END_FAST_NS     35
`define SRAM_ADDR_END_SLOW_NS     45
`define SRAM_LANE_END_FAST_NS     35
`define SRAM_LANE_END_SLOW_NS     45
`define SRAM_WE_FLOAT_FAST_NS     18
`define SRAM_WE_FLOAT_SLOW_NS     20
`define SRAM_DATA_SETUP_NS        25

// ****************************************
// Idle pin levels
// ****************************************
`define SRAM_LANES_OFF       2'h3
`define SRAM_BUS_IDLE        16'h0000

`endif

// ==== core/sram_pkg.sv ====
// Types shared by the static memory host controller and its helpers.
// Widths come from sram_params.svh.
`include "sram_params.svh"

package sram_pkg;

  // ****************************************
  // Request from the user side
  // ****************************************
  typedef struct packed {
    logic                     write;
    logic [`SRAM_ADDR_W-1:0]  addr;
    logic [`SRAM_DATA_W-1:0]  wdata;
    logic [1:0]               lane_en;
  } req_t;

  // ****************************************
  // Control pins toward the memory
  // ****************************************
  typedef struct packed {
    logic [`SRAM_ADDR_W-1:0]  addr;
    logic                     select_low_active_n;
    logic                     select_high_active;
    logic                     write_strobe_n;
    logic                     output_strobe_n;
    logic                     upper_lane_sel_n;
    logic                     lower_lane_sel_n;
  } pins_t;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_WSETUP = 5'b00010,
    ST_WPULSE = 5'b00100,
    ST_WHOLD  = 5'b01000,
    ST_READ   = 5'b10000
  } state_t;

endpackage : sram_pkg

// ==== core/sram_cycle_timer.sv ====
// Down counter that times strobe widths for the memory host controller.
// Assumes the caller loads it with the wanted count less one.
`timescale 1ns/100ps
`default_nettype none

module sram_cycle_timer #(
  parameter int W = 4
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic              done
);

  logic [W-1:0] count_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      count_ff <= '0;
    end else if (load) begin
      count_ff <= load_val;
    end else if (count_ff != '0) begin
      count_ff <= count_ff - 1'b1;
    end
  end

  assign done = (count_ff == '0);

endmodule : sram_cycle_timer
`default_nettype wire

// ==== core/sram_data_io.sv ====
// Data pin driver and read capture for the memory host controller.
// Assumes dq_in is synchronous to clk and the pins are joined outside.
`timescale 1ns/100ps
`default_nettype none
`include "sram_params.svh"

module sram_data_io (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    drive,
  input  wire logic [`SRAM_DATA_W-1:0] wdata,
  input  wire logic                    capture,
  input  wire logic [1:0]              lane_en,
  input  wire logic [`SRAM_DATA_W-1:0] dq_in,
  output logic      [`SRAM_DATA_W-1:0] dq_out,
  output logic                         dq_oe_n,
  output logic      [`SRAM_DATA_W-1:0] rdata
);

  always_ff @(posedge clk) begin
    if (rst) begin
      dq_out  <= `SRAM_BUS_IDLE;
      dq_oe_n <= 1'b1;
    end else begin
      dq_out  <= drive ? wdata : dq_out;
      dq_oe_n <= ~drive;
    end
  end

  // Lanes not read come back as zero, never as floating bus
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= `SRAM_BUS_IDLE;
    end else if (capture) begin
      rdata <= {dq_in[15:8] & {`SRAM_LANE_W{lane_en[1]}},
                dq_in[7:0]  & {`SRAM_LANE_W{lane_en[0]}}};
    end
  end

endmodule : sram_data_io
`default_nettype wire

// ==== core/sram_host_ctrl.sv ====
// Host controller for a 256K x 16 asynchronous static memory.
// Assumes one 40 MHz clock, synchronous inputs and an outside bus resolver.
//
// Summary of operation
// - Memory writes only while strobe, both selects and a lane select overlap.
// - All write controls are active before the write strobe falls.
// - Write data is set up 25 ns before and held after write end.
// - Write strobe stays high through every read.
// - Address is valid no later than the select falls.
// - Idle means selects off and both lane selects high.
// - Write strobe low at least data setup plus strobe-to-float time.
// - Address stable at least 35 or 45 ns before write end.
// - Address valid at write start and may change right at write end.
// - Lane select low at least 35 or 45 ns before write end.
`timescale 1ns/100ps
`default_nettype none
`include "sram_params.svh"

module sram_host_ctrl #(
  parameter bit FAST_GRADE = 1'b1,
  parameter int TIMER_W    = 4
) (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    req_valid,
  input  wire sram_pkg::req_t          req,
  output logic                         req_ready,
  output logic                         rsp_valid,
  output logic [`SRAM_DATA_W-1:0]      rdata,
  output sram_pkg::pins_t              pins,
  input  wire logic [`SRAM_DATA_W-1:0] dq_in,
  output logic [`SRAM_DATA_W-1:0]      dq_out,
  output logic                         dq_oe_n
);

  // ****************************************
  // Cycle counts
  // ****************************************
  function automatic int ceil_cyc(input int ns);
    int c;
    c = (ns + `SRAM_CLK_PERIOD_NS - 1) / `SRAM_CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : ceil_cyc

  function automatic int max2(input int a, input int b);
    return (a > b) ? a : b;
  endfunction : max2

  localparam int WE_W_NS  = FAST_GRADE ? `SRAM_WE_WIDTH_FAST_NS : `SRAM_WE_WIDTH_SLOW_NS;
  localparam int AW_NS    = FAST_GRADE ? `SRAM_ADDR_END_FAST_NS : `SRAM_ADDR_END_SLOW_NS;
  localparam int BW_NS    = FAST_GRADE ? `SRAM_LANE_END_FAST_NS : `SRAM_LANE_END_SLOW_NS;
  localparam int FLT_NS   = FAST_GRADE ? `SRAM_WE_FLOAT_FAST_NS : `SRAM_WE_FLOAT_SLOW_NS;
  localparam int WC_NS    = FAST_GRADE ? `SRAM_WR_PERIOD_FAST_NS : `SRAM_WR_PERIOD_SLOW_NS;
  localparam int AA_NS    = FAST_GRADE ? `SRAM_ADDR_VALID_FAST_NS : `SRAM_ADDR_VALID_SLOW_NS;
  localparam int DOE_NS   = FAST_GRADE ? `SRAM_OE_VALID_FAST_NS : `SRAM_OE_VALID_SLOW_NS;
  localparam int DBE_NS   = FAST_GRADE ? `SRAM_LANE_VALID_FAST_NS : `SRAM_LANE_VALID_SLOW_NS;
  localparam int RC_NS    = FAST_GRADE ? `SRAM_RD_PERIOD_FAST_NS : `SRAM_RD_PERIOD_SLOW_NS;

  // Strobe width covers setup, address, lane, data and float-time minimums
  localparam int PULSE_RAW = max2(max2(ceil_cyc(WE_W_NS), ceil_cyc(AW_NS)),
                                  max2(ceil_cyc(BW_NS),
                                       ceil_cyc(`SRAM_DATA_SETUP_NS + FLT_NS)));
  // A write spans setup + pulse + hold cycles
  localparam int PULSE_CYC = max2(PULSE_RAW, ceil_cyc(WC_NS) - 2);
  localparam int READ_CYC  = max2(max2(ceil_cyc(AA_NS), ceil_cyc(DOE_NS)),
                                  max2(ceil_cyc(DBE_NS), ceil_cyc(RC_NS)));

  // ****************************************
  // Sequencer
  // ****************************************
  sram_pkg::state_t state_ff;
  sram_pkg::state_t nxt_state;
  sram_pkg::req_t   req_ff;
  logic             timer_done;
  logic             timer_load;
  logic [TIMER_W-1:0] timer_val;

  assign req_ready = (state_ff == sram_pkg::ST_IDLE);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      sram_pkg::ST_IDLE: begin
        if (req_valid) begin
          nxt_state = req.write ? sram_pkg::ST_WSETUP : sram_pkg::ST_READ;
        end
      end
      sram_pkg::ST_WSETUP: begin
        nxt_state = sram_pkg::ST_WPULSE;
      end
      sram_pkg::ST_WPULSE: begin
        if (timer_done) begin
          nxt_state = sram_pkg::ST_WHOLD;
        end
      end
      sram_pkg::ST_WHOLD: begin
        nxt_state = sram_pkg::ST_IDLE;
      end
      sram_pkg::ST_READ: begin
        if (timer_done) begin
          nxt_state = sram_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_state = sram_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= sram_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      req_ff <= '0;
    end else if (req_ready && req_valid) begin
      req_ff <= req;
    end
  end

  // Timer reloads on entry to each timed state
  assign timer_load = (state_ff == sram_pkg::ST_WSETUP) ||
                      (req_ready && req_valid && !req.write);
  assign timer_val  = (state_ff == sram_pkg::ST_WSETUP) ?
                      TIMER_W'(PULSE_CYC - 1) : TIMER_W'(READ_CYC - 1);

  sram_cycle_timer #(
    .W (TIMER_W)
  ) u_timer (
    .clk      (clk),
    .rst      (rst),
    .load     (timer_load),
    .load_val (timer_val),
    .done     (timer_done)
  );

  // ****************************************
  // Control pins
  // ****************************************
  sram_pkg::req_t nxt_cur;
  logic           nxt_sel;
  logic           nxt_we;
  logic           nxt_rd;

  assign nxt_cur = (req_ready && req_valid) ? req : req_ff;
  // Address and selects move together, so address never trails select
  assign nxt_sel = (nxt_state != sram_pkg::ST_IDLE);
  // No lane enabled: strobe stays high, so the cycle stores nothing
  assign nxt_we  = (nxt_state == sram_pkg::ST_WPULSE) &&
                   (nxt_cur.lane_en != 2'h0);
  assign nxt_rd  = (nxt_state == sram_pkg::ST_READ);

  always_ff @(posedge clk) begin
    if (rst) begin
      pins.addr                <= '0;
      pins.select_low_active_n <= 1'b1;
      pins.select_high_active  <= 1'b0;
      pins.write_strobe_n      <= 1'b1;
      pins.output_strobe_n     <= 1'b1;
      pins.upper_lane_sel_n    <= 1'b1;
      pins.lower_lane_sel_n    <= 1'b1;
    end else begin
      pins.addr                <= nxt_sel ? nxt_cur.addr : pins.addr;
      pins.select_low_active_n <= ~nxt_sel;
      pins.select_high_active  <= nxt_sel;
      pins.write_strobe_n      <= ~nxt_we;
      pins.output_strobe_n     <= ~nxt_rd;
      pins.upper_lane_sel_n    <= ~(nxt_sel & nxt_cur.lane_en[1]);
      pins.lower_lane_sel_n    <= ~(nxt_sel & nxt_cur.lane_en[0]);
    end
  end

  // ****************************************
  // Data pins and response
  // ****************************************
  logic drive_data;
  logic capture;

  // Read ends in idle, so the memory has a full cycle to float first
  assign drive_data = (nxt_state == sram_pkg::ST_WSETUP) ||
                      (nxt_state == sram_pkg::ST_WPULSE) ||
                      (nxt_state == sram_pkg::ST_WHOLD);
  // Sample on the edge that ends the access time
  assign capture = (state_ff == sram_pkg::ST_READ) && timer_done;

  sram_data_io u_data (
    .clk     (clk),
    .rst     (rst),
    .drive   (drive_data),
    .wdata   (nxt_cur.wdata),
    .capture (capture),
    .lane_en (req_ff.lane_en),
    .dq_in   (dq_in),
    .dq_out  (dq_out),
    .dq_oe_n (dq_oe_n),
    .rdata   (rdata)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      rsp_valid <= 1'b0;
    end else begin
      rsp_valid <= capture || (state_ff == sram_pkg::ST_WHOLD);
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  localparam int RD_LAST = READ_CYC - 1;
  logic [TIMER_W-1:0] we_low_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      we_low_ff <= '0;
    end else if (!pins.write_strobe_n) begin
      we_low_ff <= we_low_ff + 1'b1;
    end else begin
      we_low_ff <= '0;
    end
  end

  property p_write_overlap;
    @(posedge clk) disable iff (rst)
      !pins.write_strobe_n |-> !pins.select_low_active_n && pins.select_high_active &&
        !(pins.upper_lane_sel_n && pins.lower_lane_sel_n);
  endproperty
  a_write_overlap: assert property (p_write_overlap)
    else $error("write strobe low outside full select overlap");

  property p_controls_first;
    @(posedge clk) disable iff (rst)
      $fell(pins.write_strobe_n) |-> $past(!pins.select_low_active_n) &&
        $past(pins.select_high_active) && $past(!dq_oe_n);
  endproperty
  a_controls_first: assert property (p_controls_first)
    else $error("write strobe fell before selects and data were set");

  property p_data_setup;
    @(posedge clk) disable iff (rst)
      $rose(pins.write_strobe_n) |-> !dq_oe_n && $stable(dq_out) && $past(!dq_oe_n, 2);
  endproperty
  a_data_setup: assert property (p_data_setup)
    else $error("write data not held across write end");

  property p_read_we_high;
    @(posedge clk) disable iff (rst)
      !pins.output_strobe_n |-> pins.write_strobe_n && dq_oe_n;
  endproperty
  a_read_we_high: assert property (p_read_we_high)
    else $error("write strobe or host drive active during read");

  property p_addr_stable;
    @(posedge clk) disable iff (rst)
      (!pins.select_low_active_n && $past(!pins.select_low_active_n)) |-> $stable(pins.addr);
  endproperty
  a_addr_stable: assert property (p_addr_stable)
    else $error("address changed while selected");

  property p_idle_deselect;
    @(posedge clk) disable iff (rst)
      (state_ff == sram_pkg::ST_IDLE) |-> pins.select_low_active_n &&
        pins.upper_lane_sel_n && pins.lower_lane_sel_n;
  endproperty
  a_idle_deselect: assert property (p_idle_deselect)
    else $error("memory left selected while idle");

  property p_we_width;
    @(posedge clk) disable iff (rst)
      $rose(pins.write_strobe_n) |-> we_low_ff == TIMER_W'(PULSE_CYC);
  endproperty
  a_we_width: assert property (p_we_width)
    else $error("write strobe width wrong");

  property p_lane_stable;
    @(posedge clk) disable iff (rst)
      !pins.write_strobe_n |-> $stable(pins.upper_lane_sel_n) &&
        $stable(pins.lower_lane_sel_n);
  endproperty
  a_lane_stable: assert property (p_lane_stable)
    else $error("lane select moved during write strobe");

  property p_read_time;
    @(posedge clk) disable iff (rst)
      $fell(pins.output_strobe_n) |-> ##RD_LAST !pins.output_strobe_n ##1
        pins.output_strobe_n && rsp_valid;
  endproperty
  a_read_time: assert property (p_read_time)
    else $error("read access time or response wrong");

  c_write: cover property (@(posedge clk) disable iff (rst)
    $rose(pins.write_strobe_n) ##2 rsp_valid);
  c_read: cover property (@(posedge clk) disable iff (rst)
    capture && req_ff.lane_en == 2'h3);
  c_byte_read: cover property (@(posedge clk) disable iff (rst)
    capture && req_ff.lane_en == 2'h2);
  c_back_to_back: cover property (@(posedge clk) disable iff (rst)
    rsp_valid && req_valid && req_ready);

endmodule : sram_host_ctrl
`default_nettype wire

// ==== dv/sram_mem_model.sv ====
// Behavioural model of the 256K x 16 static memory behind the host controller.
// Assumes pins and host data change on clk edges; dq_in is the resolved data bus.
`timescale 1ns/100ps
`default_nettype none
`include "sram_params.svh"

module sram_mem_model #(
  parameter int LAG = 1
) (
  input  wire logic                    clk,
  input  wire sram_pkg::pins_t         pins,
  input  wire logic [`SRAM_DATA_W-1:0] dq_out,
  input  wire logic                    dq_oe_n,
  output logic      [`SRAM_DATA_W-1:0] dq_in,
  output logic                         clash
);
  // ****************************************
  // Storage and bus drive
  // ****************************************
  logic [`SRAM_DATA_W-1:0] mem [0:(1<<`SRAM_ADDR_W)-1];
  logic [`SRAM_DATA_W-1:0] prev_ff;
  logic [`SRAM_DATA_W-1:0] word;
  logic [`SRAM_DATA_W-1:0] cur;
  logic [`SRAM_ADDR_W-1:0] addr_ff;
  logic [3:0]              lag_ff;
  logic [1:0]              lane_on;
  logic [1:0]              drv;
  logic                    sel;

  assign sel = !pins.select_low_active_n && pins.select_high_active;
  assign lane_on = ~{pins.upper_lane_sel_n, pins.lower_lane_sel_n};
  // Old address feeds the output, so data outlives an address change by a cycle
  assign word = mem[addr_ff];
  assign cur = mem[pins.addr];
  // Drive only late after the strobe; any released control floats at once
  assign drv = (sel && !pins.output_strobe_n && pins.write_strobe_n && lag_ff >= 4'(LAG))
             ? lane_on : 2'h0;
  assign clash = !dq_oe_n && (drv != 2'h0);

  // Undriven lanes show the inverse of last cycle, never a steady level
  always_comb begin
    dq_in = ~prev_ff;
    if (!dq_oe_n) begin
      dq_in = dq_out;
    end else begin
      if (drv[1]) dq_in[15:8] = word[15:8];
      if (drv[0]) dq_in[7:0] = word[7:0];
    end
  end

  always_ff @(posedge clk) begin
    prev_ff <= dq_in;
    addr_ff <= pins.addr;
    lag_ff <= (sel && !pins.output_strobe_n && lag_ff != 4'hF) ? lag_ff + 4'h1 : 4'h0;
    if (sel && !pins.write_strobe_n && lane_on != 2'h0) begin
      mem[pins.addr] <= {lane_on[1] ? dq_in[15:8] : cur[15:8],
                               lane_on[0] ? dq_in[7:0] : cur[7:0]};
    end
  end
endmodule : sram_mem_model
`default_nettype wire

// ==== dv/testbench.sv ====
// Self-checking bench for the static memory host controller.
// Assumes the memory model and the design's package and parameter header.
`timescale 1ns/100ps
`default_nettype none
`include "sram_params.svh"

module testbench;
  localparam int LIMIT = 40;
  logic                    clk;
  logic                    rst;
  logic                    req_valid;
  sram_pkg::req_t          req;
  logic                    req_ready;
  logic                    rsp_valid;
  logic [`SRAM_DATA_W-1:0] rdata;
  sram_pkg::pins_t         pins;
  sram_pkg::pins_t         pins_q;
  logic [`SRAM_DATA_W-1:0] dq_in;
  logic [`SRAM_DATA_W-1:0] dq_out;
  logic [`SRAM_DATA_W-1:0] dq_q;
  logic                    dq_oe_n;
  logic                    clash;
  int                      we_low;
  int                      n_mismatch;
  int                      check_count;

  sram_host_ctrl #(.FAST_GRADE(1'b1), .TIMER_W(4)) i_dut (
    .clk(clk), .rst(rst), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rdata(rdata), .pins(pins), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe_n(dq_oe_n));

  sram_mem_model #(.LAG(1)) i_mem (
    .clk(clk), .pins(pins), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dq_in(dq_in),
    .clash(clash));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ****************************************
  // Compare and closing
  // ****************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic results;
    $display("mismatches %0d, checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results

  // One access; called on a falling edge, returns on the answer's falling edge
  task automatic access(input logic wr, input logic [17:0] a, input logic [15:0] d,
                        input logic [1:0] le, input logic [15:0] exp, input int lat);
    int n;
    n = 0;
    req = '{write: wr, addr: a, wdata: d, lane_en: le};
    req_valid = 1'b1;
    while (req_ready !== 1'b1 && n < LIMIT) begin
      @(negedge clk);
      n++;
    end
    if (n >= LIMIT) begin
      n_mismatch++;
      results();
    end
    @(negedge clk);
    req_valid = 1'b0;
    check(32'(req_ready), 32'h0, "ready while busy");
    check(32'({pins.select_low_active_n, pins.select_high_active, pins.write_strobe_n,
               pins.output_strobe_n, pins.upper_lane_sel_n, pins.lower_lane_sel_n}),
          32'({3'b011, wr, ~le}), "first cycle pins");
    check(32'({pins.addr, dq_oe_n}), 32'({a, ~wr}), "address and drive");
    if (wr) check(32'(dq_out), 32'(d), "write data");
    n = 1;
    while (rsp_valid !== 1'b1 && n < LIMIT) begin
      @(negedge clk);
      n++;
    end
    if (n >= LIMIT) begin
      n_mismatch++;
      results();
    end
    check(32'(n), 32'(lat), "answer cycle");
    if (!wr) check(32'(rdata), 32'(exp), "read data");
    check(32'({pins.select_low_active_n, pins.select_high_active, pins.upper_lane_sel_n,
               pins.lower_lane_sel_n, pins.output_strobe_n, dq_oe_n}),
          32'h2F, "idle pins");
  endtask : access

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic sc_reset;
    check(32'({pins.select_low_active_n, pins.select_high_active, pins.write_strobe_n,
               pins.output_strobe_n, pins.upper_lane_sel_n, pins.lower_lane_sel_n}),
          32'h2F, "reset pins");
    check(32'({dq_oe_n, rsp_valid, req_ready, rdata}), 32'h50000, "reset outputs");
  endtask : sc_reset

  task automatic sc_lanes;
    access(1'b1, 18'h01234, 16'h1234, 2'b11, 16'h0000, 5);
    access(1'b0, 18'h01234, 16'h0000, 2'b11, 16'h1234, 3);
    access(1'b1, 18'h01234, 16'hABCD, 2'b10, 16'h0000, 5);
    access(1'b0, 18'h01234, 16'h0000, 2'b11, 16'hAB34, 3);
    access(1'b1, 18'h01234, 16'hEF99, 2'b01, 16'h0000, 5);
    access(1'b0, 18'h01234, 16'h0000, 2'b01, 16'h0099, 3);
    access(1'b0, 18'h01234, 16'h0000, 2'b10, 16'hAB00, 3);
    // No lane selected: the cycle runs but must leave the word alone
    access(1'b1, 18'h01234, 16'hFFFF, 2'b00, 16'h0000, 5);
    access(1'b0, 18'h01234, 16'h0000, 2'b11, 16'hAB99, 3);
  endtask : sc_lanes

  task automatic sc_bounds;
    logic [17:0] a [3] = '{18'h00000, 18'h3FFFF, 18'h20000};
    logic [15:0] d [3] = '{16'h5AA5, 16'hC33C, 16'h0FF0};
    for (int i = 0; i < 3; i++) begin
      access(1'b1, a[i], d[i], 2'b11, 16'h0000, 5);
    end
    for (int i = 0; i < 3; i++) begin
      access(1'b0, a[i], 16'h0000, 2'b11, d[i], 3);
    end
  endtask : sc_bounds

  // ****************************************
  // Pin watcher for write and read timing
  // ****************************************
  always @(negedge clk) begin
    if (!rst && (!pins.write_strobe_n || !pins_q.write_strobe_n)) begin
      check(32'(pins.addr), 32'(pins_q.addr), "address moved in write");
      check(32'(dq_out), 32'(dq_q), "data moved in write");
      check(32'({pins.select_low_active_n, pins.select_high_active, dq_oe_n,
                 pins.upper_lane_sel_n, pins.lower_lane_sel_n}),
            32'({3'b010, pins_q.upper_lane_sel_n, pins_q.lower_lane_sel_n}),
            "controls in write");
    end
    if (!rst && pins.write_strobe_n && !pins_q.write_strobe_n) begin
      check(32'(we_low), 32'h2, "strobe width");
    end
    if (!rst && !pins.output_strobe_n) begin
      check(32'({pins.write_strobe_n, clash}), 32'h2, "strobe in read");
    end
    we_low = pins.write_strobe_n ? 0 : we_low + 1;
    pins_q = pins;
    dq_q = dq_out;
  end

  initial begin
    n_mismatch = 0;
    check_count = 0;
    we_low = 0;
    rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    sc_reset();
    sc_lanes();
    sc_bounds();
    results();
  end
endmodule : testbench
`default_nettype wire
